/* File: design/ssp_pkg.sv */
// constants and carrier types of the serial port status block
// assumes a 100 MHz core clock and a 32-bit AXI4-Lite register bus
package ssp_pkg;
   // byte addresses of the registers
   localparam logic [7:0] STATUS_OFS = 8'h00;
   localparam logic [7:0] CONTROL_OFS = 8'h04;
   localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
   localparam logic [7:0] IRQ_MASK_OFS = 8'h0c;
   // status field positions
   localparam int SMP_BIT = 7;
   localparam int CKE_BIT = 6;
   localparam int DA_BIT = 5;
   localparam int STOP_BIT = 4;
   localparam int START_BIT = 3;
   localparam int RW_BIT = 2;
   localparam int UA_BIT = 1;
   localparam int BF_BIT = 0;
   // control field positions
   localparam int MODE_LSB = 0;
   localparam int CKP_BIT = 2;
   localparam int EN_BIT = 3;
   // mode codes in the control register
   localparam logic [1:0] MODE_SPI_MASTER = 2'h0;
   localparam logic [1:0] MODE_SPI_SLAVE = 2'h1;
   localparam logic [1:0] MODE_I2C_SLAVE = 2'h2;
   localparam logic [1:0] MODE_I2C_MASTER = 2'h3;
   // interrupt event bits
   localparam int IRQ_START = 0;
   localparam int IRQ_STOP = 1;
   localparam int IRQ_BF = 2;
   localparam int IRQ_MATCH = 3;
   localparam int IRQ_W = 4;
   // reset values
   localparam logic [7:0] STATUS_RST = 8'h00;
   localparam logic [3:0] CONTROL_RST = 4'h0;
   localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum {SEL_STATUS, SEL_CONTROL, SEL_IRQ_STAT, SEL_IRQ_MASK,
      SEL_NONE} ssp_sel_e;

   typedef struct packed {
      logic sample_phase_select;
      logic clock_edge_select;
      logic data_not_address;
      logic stop_seen;
      logic start_seen;
      logic read_write;
      logic update_address_flag;
      logic buffer_full_flag;
   } ssp_status_s;

   typedef struct packed {
      logic port_enable_bit;
      logic clock_idle_polarity;
      logic [1:0] mode;
   } ssp_control_s;
endpackage : ssp_pkg

/* File: design/ssp_status.sv */
// serial port status and configuration flags with AXI4-Lite access
// assumes the shift datapath reports byte and address events on I_CLK;
// pins SCK, SCL and SDA arrive asynchronously and are synchronised here
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
// Function
// - I2C: sample_phase_select 1 disables slew limiting, 0 enables
// - SPI, idle polarity low: edge select high shifts on rising SCK edge
// - SPI, idle polarity high: edge select high shifts on falling SCK edge
// - I2C start/stop flags show last condition; disable clears both
// - I2C slave: read/write holds match direction until start, stop, ack
// - I2C master: read/write reads one while a transmission is running
module ssp_status (
   input wire logic I_CLK,
   input wire logic I_SYS_RST,
   input wire logic [7:0] I_AWADDR,
   input wire logic I_AWVALID,
   output logic O_AWREADY,
   input wire logic [31:0] I_WDATA,
   input wire logic [3:0] I_WSTRB,
   input wire logic I_WVALID,
   output logic O_WREADY,
   output logic [1:0] O_BRESP,
   output logic O_BVALID,
   input wire logic I_BREADY,
   input wire logic [7:0] I_ARADDR,
   input wire logic I_ARVALID,
   output logic O_ARREADY,
   output logic [31:0] O_RDATA,
   output logic [1:0] O_RRESP,
   output logic O_RVALID,
   input wire logic I_RREADY,
   input wire logic I_SCK,
   input wire logic I_SCL,
   input wire logic I_SDA,
   input wire logic I_RX_BYTE_DONE,
   input wire logic I_RX_IS_DATA,
   input wire logic I_ADDR_MATCH,
   input wire logic I_ADDR_RW,
   input wire logic I_ACK_SEEN,
   input wire logic I_MASTER_TX_BUSY,
   input wire logic I_TX_BYTE_BUSY,
   input wire logic I_BUF_READ,
   input wire logic I_ADDR_UPDATE_REQ,
   input wire logic I_ADDR_WRITTEN,
   output logic O_SLEW_LIMIT_EN,
   output logic O_SHIFT_STROBE,
   output logic O_PORT_ENABLE,
   output logic O_IRQ
);
   function automatic ssp_pkg::ssp_sel_e reg_sel(input logic [7:0] a);
      case (a)
         ssp_pkg::STATUS_OFS: reg_sel = ssp_pkg::SEL_STATUS;
         ssp_pkg::CONTROL_OFS: reg_sel = ssp_pkg::SEL_CONTROL;
         ssp_pkg::IRQ_STAT_OFS: reg_sel = ssp_pkg::SEL_IRQ_STAT;
         ssp_pkg::IRQ_MASK_OFS: reg_sel = ssp_pkg::SEL_IRQ_MASK;
         default: reg_sel = ssp_pkg::SEL_NONE;
      endcase
   endfunction : reg_sel

   ssp_pkg::ssp_status_s status_reg;
   ssp_pkg::ssp_control_s control_reg;
   logic [ssp_pkg::IRQ_W-1:0] irq_stat_reg;
   logic [ssp_pkg::IRQ_W-1:0] irq_mask_reg;
   logic [ssp_pkg::IRQ_W-1:0] irq_next;
   logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
   logic [1:0] bresp_reg, rresp_reg;
   logic [31:0] rdata_reg;
   logic [2:0] sync1_reg, sync2_reg, sync3_reg;
   logic slew_reg, strobe_reg, irq_reg;
   logic wr_go, wr_do, rd_go, rd_do;
   ssp_pkg::ssp_sel_e wsel, rsel;
   logic is_i2c, is_i2c_slave, is_spi, enabled;
   logic sck_rise, sck_fall, shift_on_rise, start_evt, stop_evt;
   logic [31:0] rd_value;

   // bit 0 SCK, bit 1 SCL, bit 2 SDA
   always_ff @(posedge I_CLK) begin
      if (I_SYS_RST) begin
         sync1_reg <= 3'h7;
         sync2_reg <= 3'h7;
         sync3_reg <= 3'h7;
      end else begin
         sync1_reg <= {I_SDA, I_SCL, I_SCK};
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
      end
   end

   assign enabled = control_reg.port_enable_bit;
   assign is_i2c = control_reg.mode[1];
   assign is_spi = ~control_reg.mode[1];
   assign is_i2c_slave = control_reg.mode == ssp_pkg::MODE_I2C_SLAVE;
   assign sck_rise = sync2_reg[0] & ~sync3_reg[0];
   assign sck_fall = ~sync2_reg[0] & sync3_reg[0];
   // sda moving while scl stays high marks a bus condition
   assign start_evt = ~sync2_reg[2] & sync3_reg[2] & sync2_reg[1]
      & sync3_reg[1];
   assign stop_evt = sync2_reg[2] & ~sync3_reg[2] & sync2_reg[1]
      & sync3_reg[1];
   assign shift_on_rise = status_reg.clock_edge_select
      ^ control_reg.clock_idle_polarity;

   assign wsel = reg_sel(I_AWADDR);
   assign rsel = reg_sel(I_ARADDR);
   // address and data are taken together, one write at a time
   assign wr_go = I_AWVALID & I_WVALID & ~awready_reg & ~bvalid_reg;
   assign wr_do = awready_reg;
   assign rd_go = I_ARVALID & ~arready_reg & ~rvalid_reg;
   assign rd_do = arready_reg;

   always_ff @(posedge I_CLK) begin
      if (I_SYS_RST) begin
         awready_reg <= 1'b0;
         wready_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= ssp_pkg::RESP_OKAY;
      end else begin
         awready_reg <= wr_go;
         wready_reg <= wr_go;
         if (wr_do) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= (wsel == ssp_pkg::SEL_NONE) ?
               ssp_pkg::RESP_SLVERR : ssp_pkg::RESP_OKAY;
         end else if (I_BREADY) begin
            bvalid_reg <= 1'b0;
         end
      end
   end

   always_comb begin
      rd_value = 32'h0;
      case (rsel)
         ssp_pkg::SEL_STATUS: rd_value[7:0] = status_reg;
         ssp_pkg::SEL_CONTROL: rd_value[3:0] = control_reg;
         ssp_pkg::SEL_IRQ_STAT: rd_value[3:0] = irq_stat_reg;
         ssp_pkg::SEL_IRQ_MASK: rd_value[3:0] = irq_mask_reg;
         default: rd_value = 32'h0;
      endcase
   end

   always_ff @(posedge I_CLK) begin
      if (I_SYS_RST) begin
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0;
         rresp_reg <= ssp_pkg::RESP_OKAY;
      end else begin
         arready_reg <= rd_go;
         if (rd_do) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_value;
            rresp_reg <= (rsel == ssp_pkg::SEL_NONE) ?
               ssp_pkg::RESP_SLVERR : ssp_pkg::RESP_OKAY;
         end else if (I_RREADY) begin
            rvalid_reg <= 1'b0;
         end
      end
   end

   // software-writable configuration
   always_ff @(posedge I_CLK) begin
      if (I_SYS_RST) begin
         control_reg <= ssp_pkg::CONTROL_RST;
         irq_mask_reg <= ssp_pkg::IRQ_MASK_RST;
         status_reg.sample_phase_select <= 1'b0;
         status_reg.clock_edge_select <= 1'b0;
      end else if (wr_do && I_WSTRB[0]) begin
         if (wsel == ssp_pkg::SEL_CONTROL)
            control_reg <= I_WDATA[3:0];
         if (wsel == ssp_pkg::SEL_IRQ_MASK)
            irq_mask_reg <= I_WDATA[ssp_pkg::IRQ_W-1:0];
         if (wsel == ssp_pkg::SEL_STATUS) begin
            status_reg.sample_phase_select <= I_WDATA[ssp_pkg::SMP_BIT];
            status_reg.clock_edge_select <= I_WDATA[ssp_pkg::CKE_BIT];
         end
      end
   end

   // bus conditions; a disabled port forgets both
   always_ff @(posedge I_CLK) begin
      if (I_SYS_RST || !enabled) begin
         status_reg.start_seen <= 1'b0;
         status_reg.stop_seen <= 1'b0;
      end else if (is_i2c && start_evt) begin
         status_reg.start_seen <= 1'b1;
         status_reg.stop_seen <= 1'b0;
      end else if (is_i2c && stop_evt) begin
         status_reg.stop_seen <= 1'b1;
         status_reg.start_seen <= 1'b0;
      end
   end

   always_ff @(posedge I_CLK) begin
      if (I_SYS_RST) begin
         status_reg.read_write <= 1'b0;
      end else if (!is_i2c) begin
         status_reg.read_write <= 1'b0;
      end else if (!is_i2c_slave) begin
         status_reg.read_write <= I_MASTER_TX_BUSY;
      end else if (I_ADDR_MATCH) begin
         status_reg.read_write <= I_ADDR_RW;
      end else if (start_evt || stop_evt || I_ACK_SEEN) begin
         status_reg.read_write <= 1'b0;
      end
   end

   // a new byte wins over a read in the same cycle
   always_ff @(posedge I_CLK) begin
      if (I_SYS_RST) begin
         status_reg.buffer_full_flag <= 1'b0;
         status_reg.data_not_address <= 1'b0;
      end else begin
         if (I_RX_BYTE_DONE || (is_i2c && I_TX_BYTE_BUSY))
            status_reg.buffer_full_flag <= 1'b1;
         else if (I_BUF_READ)
            status_reg.buffer_full_flag <= 1'b0;
         if (is_i2c && I_RX_BYTE_DONE)
            status_reg.data_not_address <= I_RX_IS_DATA;
      end
   end

   always_ff @(posedge I_CLK) begin
      if (I_SYS_RST)
         status_reg.update_address_flag <= 1'b0;
      else if (is_i2c_slave && I_ADDR_UPDATE_REQ)
         status_reg.update_address_flag <= 1'b1;
      else if (I_ADDR_WRITTEN)
         status_reg.update_address_flag <= 1'b0;
   end

   // read of the event register clears it, but a new event survives
   always_comb begin
      irq_next = irq_stat_reg;
      if (rd_do && rsel == ssp_pkg::SEL_IRQ_STAT)
         irq_next = '0;
      if (enabled && is_i2c && start_evt)
         irq_next[ssp_pkg::IRQ_START] = 1'b1;
      if (enabled && is_i2c && stop_evt)
         irq_next[ssp_pkg::IRQ_STOP] = 1'b1;
      if (I_RX_BYTE_DONE)
         irq_next[ssp_pkg::IRQ_BF] = 1'b1;
      if (I_ADDR_MATCH)
         irq_next[ssp_pkg::IRQ_MATCH] = 1'b1;
   end

   always_ff @(posedge I_CLK) begin
      if (I_SYS_RST) begin
         irq_stat_reg <= '0;
         irq_reg <= 1'b0;
      end else begin
         irq_stat_reg <= irq_next;
         irq_reg <= |(irq_next & irq_mask_reg);
      end
   end

   // slew limiting only matters on the open-drain I2C pins
   always_ff @(posedge I_CLK) begin
      if (I_SYS_RST) begin
         slew_reg <= 1'b0;
         strobe_reg <= 1'b0;
      end else begin
         slew_reg <= is_i2c & ~status_reg.sample_phase_select;
         strobe_reg <= enabled & is_spi
            & (shift_on_rise ? sck_rise : sck_fall);
      end
   end

   assign O_AWREADY = awready_reg;
   assign O_WREADY = wready_reg;
   assign O_BVALID = bvalid_reg;
   assign O_BRESP = bresp_reg;
   assign O_ARREADY = arready_reg;
   assign O_RVALID = rvalid_reg;
   assign O_RDATA = rdata_reg;
   assign O_RRESP = rresp_reg;
   assign O_SLEW_LIMIT_EN = slew_reg;
   assign O_SHIFT_STROBE = strobe_reg;
   assign O_PORT_ENABLE = control_reg.port_enable_bit;
   assign O_IRQ = irq_reg;

   sequence sck_up_s;
      !sync3_reg[0] ##1 sync3_reg[0];
   endsequence
   sequence sck_down_s;
      sync3_reg[0] ##1 !sync3_reg[0];
   endsequence

   slew_off_a: assert property (
      @(posedge I_CLK) disable iff (I_SYS_RST)
      is_i2c && status_reg.sample_phase_select |=> !O_SLEW_LIMIT_EN)
      else $error("slew limit left on");
   rise_shift_a: assert property (
      @(posedge I_CLK) disable iff (I_SYS_RST)
      enabled && is_spi && !control_reg.clock_idle_polarity
      && status_reg.clock_edge_select ##0 sck_up_s |-> O_SHIFT_STROBE)
      else $error("no shift on rising edge");
   fall_shift_a: assert property (
      @(posedge I_CLK) disable iff (I_SYS_RST)
      enabled && is_spi && control_reg.clock_idle_polarity
      && status_reg.clock_edge_select ##0 sck_down_s |-> O_SHIFT_STROBE)
      else $error("no shift on falling edge");
   start_flag_a: assert property (
      @(posedge I_CLK) disable iff (I_SYS_RST)
      enabled && is_i2c && start_evt |=>
      status_reg.start_seen && !status_reg.stop_seen)
      else $error("start not flagged");
   cond_clear_a: assert property (
      @(posedge I_CLK) disable iff (I_SYS_RST)
      !enabled |=> !status_reg.start_seen && !status_reg.stop_seen)
      else $error("flags kept while disabled");
   match_dir_a: assert property (
      @(posedge I_CLK) disable iff (I_SYS_RST)
      is_i2c_slave && I_ADDR_MATCH |=>
      status_reg.read_write == $past(I_ADDR_RW))
      else $error("direction not held");
   master_busy_a: assert property (
      @(posedge I_CLK) disable iff (I_SYS_RST)
      control_reg.mode == ssp_pkg::MODE_I2C_MASTER ##1
      control_reg.mode == ssp_pkg::MODE_I2C_MASTER
      |-> status_reg.read_write == $past(I_MASTER_TX_BUSY))
      else $error("busy not shown");
   buf_full_a: assert property (
      @(posedge I_CLK) disable iff (I_SYS_RST)
      I_RX_BYTE_DONE |=> status_reg.buffer_full_flag)
      else $error("buffer full not set");
endmodule : ssp_status

/* File: verification/ssp_peer.sv */
// far-side serial peer: moves SCK in SPI frames, SCL/SDA in I2C
// assumes the block samples these pins asynchronously on its own clock
`timescale 1ns/100ps
module ssp_peer (
   output logic o_sck,
   output logic o_scl,
   output logic o_sda
);
   // I2C lines rest at the pulled-up level; SCK only moves on request
   initial begin
      o_sck = 1'h0;
      o_scl = 1'h1;
      o_sda = 1'h1;
   end
   // half of the 125 ns link clock period
   task sck_to(input logic v);
      #62.5 o_sck = v;
   endtask : sck_to
   task start_cond;
      #62.5 o_sda = 1'h0;
      #62.5 o_scl = 1'h0;
      #62.5;
   endtask : start_cond
   task stop_cond;
      o_sda = 1'h0;
      #62.5 o_scl = 1'h1;
      #62.5 o_sda = 1'h1;
      #62.5;
   endtask : stop_cond
endmodule : ssp_peer

/* File: verification/tb_top.sv */
// self-checking bench for the serial port status block
// assumes ssp_pkg is compiled first; peer model drives the pins
`timescale 1ns/100ps
`define CHK(n, e, a) begin \
   num_checks++; \
   if ((a) !== (e)) begin \
      error_cnt++; \
      $display("Error %s exp %h got %h", n, e, a); \
   end \
end
module tb_top;
   logic clk = 1'h0;
   logic rst = 1'h1;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'hf;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
   logic arvalid = 1'h0, rready = 1'h0, rx_done = 1'h0, rx_data = 1'h0;
   logic match = 1'h0, addr_rw = 1'h0, ack = 1'h0, mtx = 1'h0;
   logic tx_busy = 1'h0, buf_rd = 1'h0, ua_req = 1'h0, ua_wr = 1'h0;
   logic awready, wready, bvalid, arready, rvalid, slew, strobe, pen, irq;
   logic [1:0] bresp, rresp, rd_r, wb_r;
   logic [31:0] rdata, rd_d;
   wire sck, scl, sda;
   int error_cnt = 0, num_checks = 0, scnt = 0;

   always #5 clk = ~clk;
   always @(posedge clk) if (strobe === 1'h1) scnt <= scnt + 1;

   ssp_peer ssp_peer_i (.o_sck(sck), .o_scl(scl), .o_sda(sda));
   ssp_status ssp_status_i (
      .I_CLK(clk), .I_SYS_RST(rst), .I_AWADDR(awaddr), .I_AWVALID(awvalid),
      .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(wstrb),
      .I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp),
      .O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(araddr),
      .I_ARVALID(arvalid), .O_ARREADY(arready), .O_RDATA(rdata),
      .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready), .I_SCK(sck),
      .I_SCL(scl), .I_SDA(sda), .I_RX_BYTE_DONE(rx_done),
      .I_RX_IS_DATA(rx_data), .I_ADDR_MATCH(match), .I_ADDR_RW(addr_rw),
      .I_ACK_SEEN(ack), .I_MASTER_TX_BUSY(mtx), .I_TX_BYTE_BUSY(tx_busy),
      .I_BUF_READ(buf_rd), .I_ADDR_UPDATE_REQ(ua_req),
      .I_ADDR_WRITTEN(ua_wr), .O_SLEW_LIMIT_EN(slew),
      .O_SHIFT_STROBE(strobe), .O_PORT_ENABLE(pen), .O_IRQ(irq)
   );

   task end_sim;
      if (error_cnt == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : end_sim

   // channels are released one by one as each ready is seen
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do begin
         @(posedge clk);
         if (awready === 1'h1) awvalid <= 1'h0;
         if (wready === 1'h1) wvalid <= 1'h0;
         if (bvalid === 1'h1) begin
            bready <= 1'h0;
            wb_r = bresp;
         end
      end while (bready);
   endtask : wr
   task rd(input logic [7:0] a);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do begin
         @(posedge clk);
         if (arready === 1'h1) arvalid <= 1'h0;
         if (rvalid === 1'h1) begin
            rready <= 1'h0;
            rd_d = rdata;
            rd_r = rresp;
         end
      end while (rready);
   endtask : rd
   task ctl(input logic [3:0] v);
      wr(ssp_pkg::CONTROL_OFS, {28'h0, v});
   endtask : ctl
   task st;
      rd(ssp_pkg::STATUS_OFS);
   endtask : st

   task t_reset;
      st;
      `CHK("status", ssp_pkg::STATUS_RST, rd_d[7:0])
      rd(ssp_pkg::IRQ_MASK_OFS);
      `CHK("mask", 32'h0, rd_d)
      rd(8'h10);
      `CHK("unmapped resp", ssp_pkg::RESP_SLVERR, rd_r)
      `CHK("unmapped data", 32'h0, rd_d)
      wr(8'h10, 32'hff);
      `CHK("unmapped wresp", ssp_pkg::RESP_SLVERR, wb_r)
      @(posedge clk) wstrb <= 4'he;
      ctl(4'hf);
      `CHK("wresp", ssp_pkg::RESP_OKAY, wb_r)
      @(posedge clk) wstrb <= 4'hf;
      rd(ssp_pkg::CONTROL_OFS);
      `CHK("lane 0 off", 32'h0, rd_d)
   endtask : t_reset

   task t_slew;
      ctl(4'ha);
      wr(ssp_pkg::STATUS_OFS, 32'h80);
      repeat (3) @(posedge clk);
      `CHK("slew limit", 1'h0, slew)
      `CHK("enable", 1'h1, pen)
      st;
      `CHK("sample sel", 1'h1, rd_d[7])
      wr(ssp_pkg::STATUS_OFS, 32'h0);
      repeat (3) @(posedge clk);
      `CHK("slew limit", 1'h1, slew)
   endtask : t_slew

   // idle level follows polarity, so the first edge is rising when low
   task t_spi;
      int b;
      logic e1;
      for (int k = 0; k < 4; k++) begin
         ssp_peer_i.sck_to(k[1]);
         ctl({1'h1, k[1], 1'h0, k[0]});
         wr(ssp_pkg::STATUS_OFS, {25'h0, k[0], 6'h0});
         repeat (4) @(posedge clk);
         b = scnt;
         // edge select high always picks the first edge away from idle
         e1 = k[0];
         ssp_peer_i.sck_to(!k[1]);
         repeat (6) @(posedge clk);
         `CHK("strobe edge1", int'(e1), scnt - b)
         ssp_peer_i.sck_to(k[1]);
         repeat (6) @(posedge clk);
         `CHK("strobe pulse", 1, scnt - b)
      end
   endtask : t_spi

   task t_cond;
      ctl(4'ha);
      wr(ssp_pkg::IRQ_MASK_OFS, 32'h3);
      ssp_peer_i.start_cond;
      st;
      `CHK("stop start", 2'h1, rd_d[4:3])
      `CHK("irq start", 1'h1, irq)
      rd(ssp_pkg::IRQ_STAT_OFS);
      `CHK("events", 32'h1, rd_d)
      repeat (2) @(posedge clk);
      `CHK("irq cleared", 1'h0, irq)
      wr(ssp_pkg::IRQ_MASK_OFS, 32'h0);
      ssp_peer_i.stop_cond;
      st;
      `CHK("stop start", 2'h2, rd_d[4:3])
      `CHK("irq masked", 1'h0, irq)
      wr(ssp_pkg::IRQ_MASK_OFS, 32'h2);
      repeat (2) @(posedge clk);
      `CHK("irq stop", 1'h1, irq)
      rd(ssp_pkg::IRQ_STAT_OFS);
      ctl(4'h2);
      st;
      `CHK("disabled", 2'h0, rd_d[4:3])
   endtask : t_cond

   task t_rw;
      ctl(4'ha);
      @(posedge clk);
      addr_rw <= 1'h1;
      match <= 1'h1;
      @(posedge clk) match <= 1'h0;
      st;
      `CHK("rw match", 1'h1, rd_d[2])
      @(posedge clk) ack <= 1'h1;
      @(posedge clk) ack <= 1'h0;
      st;
      `CHK("rw ack", 1'h0, rd_d[2])
      ctl(4'hb);
      @(posedge clk) mtx <= 1'h1;
      st;
      `CHK("rw busy", 1'h1, rd_d[2])
      @(posedge clk) mtx <= 1'h0;
      st;
      `CHK("rw idle", 1'h0, rd_d[2])
   endtask : t_rw

   task t_bf;
      ctl(4'ha);
      @(posedge clk);
      rx_data <= 1'h1;
      rx_done <= 1'h1;
      @(posedge clk) rx_done <= 1'h0;
      st;
      `CHK("full", 2'h3, {rd_d[5], rd_d[0]})
      @(posedge clk) buf_rd <= 1'h1;
      @(posedge clk) buf_rd <= 1'h0;
      st;
      `CHK("read out", 1'h0, rd_d[0])
      @(posedge clk) tx_busy <= 1'h1;
      st;
      `CHK("sending", 1'h1, rd_d[0])
      @(posedge clk) tx_busy <= 1'h0;
      @(posedge clk) ua_req <= 1'h1;
      @(posedge clk) ua_req <= 1'h0;
      st;
      `CHK("update addr", 1'h1, rd_d[1])
      @(posedge clk) ua_wr <= 1'h1;
      @(posedge clk) ua_wr <= 1'h0;
      st;
      `CHK("addr written", 1'h0, rd_d[1])
   endtask : t_bf

   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'h0;
      t_reset;
      t_slew;
      t_spi;
      t_cond;
      t_rw;
      t_bf;
      end_sim;
   end
   // the whole run needs a few hundred cycles
   initial begin
      #200000;
      error_cnt++;
      end_sim;
   end
endmodule : tb_top
